/* File: common/swc_map.svh */
// Register offsets, field positions, reset values and timing counts of the sleep and wake controller.
// Assumes a Wishbone slave with 32-bit data and byte addresses, and a 20 MHz oscillator.
// How it works
// - Sleep only on the power-down instruction
// - Entry clears watchdog, keeps it running
// - Entry clears power-down flag, sets timeout flag
// - Sleep stops main oscillator, timer one untouched
// - Ports hold their drive state in sleep
// - Watchdog reset never drives master clear
// - Master clear resets; watchdog, interrupt continue
// - Power-down set at power-up; watchdog wake clears timeout
// - Only the listed sources can wake
// - Next instruction is prefetched during sleep
// - Wake needs source enable, ignores global enable
// - Global enable picks inline or vector 0004h
// - Any wake clears the watchdog
// - Pending enabled interrupt with global enable clear makes sleep a no-op
// - Interrupt during sleep instruction wakes at once
// - Crystal modes wait 1024 periods before resuming
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// Register byte offsets
`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_STATUS 8'h04
`define SWC_OFF_CHANGE_MASK 8'h08
`define SWC_OFF_CORE_IRQ 8'h0c
`define SWC_OFF_PIE_ONE 8'h10
`define SWC_OFF_PIE_TWO 8'h14
`define SWC_OFF_PIR_ONE 8'h18
`define SWC_OFF_PIR_TWO 8'h1c
`define SWC_OFF_EVT 8'h20
`define SWC_OFF_EVT_MASK 8'h24

// Control register fields
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_OSC_LO 1
`define SWC_CTRL_OSC_HI 3
`define SWC_CTRL_T1_ASYNC 4
`define SWC_CTRL_RX_SLAVE 5
`define SWC_CTRL_AD_RC 6
`define SWC_CTRL_SSP_SLAVE 7

// Status fields
`define SWC_ST_PD 0
`define SWC_ST_TO 1
`define SWC_ST_SLEEP 2

// Core interrupt control fields
`define SWC_CI_GIE 7
`define SWC_CI_PERIPHERAL_IRQ_GATE 6
`define SWC_CI_EXT_PIN_IRQ_ENABLE 4
`define SWC_CI_PORTB_CHANGE_ENABLE 3
`define SWC_CI_EXT_PIN_IRQ_FLAG 1
`define SWC_CI_PORTB_CHANGE_FLAG 0

// Peripheral bits used for wake
`define SWC_P1_AD 6
`define SWC_P1_RC 5
`define SWC_P1_SSP 3
`define SWC_P1_CAPTURE_UNIT_ONE 2
`define SWC_P1_TIMER_ONE 0

// Event bits
`define SWC_EV_ENTER 0
`define SWC_EV_WAKE_IRQ 1
`define SWC_EV_WAKE_WDT 2
`define SWC_EV_NOP 3

// Reset values
`define SWC_RST_CTRL 8'h01
`define SWC_RST_REG 8'h00

// Timing
`define SWC_OST_PERIODS 1024
`define SWC_DUMMY_CYCLES 2
`define SWC_VECTOR 13'h0004

`endif

/* File: common/swc_pkg.sv */
// Types of the sleep and wake controller.
// Assumes the map header is compiled alongside.
package swc_pkg;
  typedef enum logic [4:0] {
    SWC_RUN = 5'h01,
    SWC_SLEEP = 5'h02,
    SWC_OST = 5'h04,
    SWC_DUMMY = 5'h08,
    SWC_RESUME = 5'h10
  } swc_state_e;
  typedef enum logic [2:0] {
    SWC_OSC_LP = 3'h0,
    SWC_OSC_XT = 3'h1,
    SWC_OSC_HS = 3'h2,
    SWC_OSC_EC = 3'h3,
    SWC_OSC_RC = 3'h4
  } swc_osc_e;
endpackage : swc_pkg

/* File: verilog/swc_sleep_wake_control.sv */
// Sleep entry and wake control: watchdog clear, status flags, oscillator gate, port hold, resume path.
// Assumes a classic Wishbone master on the same clock, and core strobes synchronous to sys_clk_in.
`timescale 1ns/100ps
`include "swc_map.svh"
module swc_sleep_wake_control (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Core instruction flow
  input wire logic sleep_instr_in,
  input wire logic [12:0] pc_in,
  output logic core_hold_out,
  output logic prefetch_out,
  output logic [12:0] prefetch_addr_out,
  output logic resume_out,
  output logic vector_out,
  output logic [12:0] vector_addr_out,
  output logic dummy_cycle_out,
  // Watchdog
  input wire logic wdt_timeout_in,
  output logic wdt_clear_out,
  output logic wdt_reset_out,
  // Pins
  input wire logic master_clear_pin_in,
  input wire logic ext_pin_in,
  input wire logic [7:0] portb_in,
  // Peripheral interrupt requests
  input wire logic timer_one_irq_in,
  input wire logic rx_irq_in,
  input wire logic ad_irq_in,
  input wire logic capture_unit_one_irq_in,
  input wire logic capture_unit_two_irq_in,
  input wire logic sync_serial_port_irq_in,
  // Oscillator and ports
  output logic main_osc_enable_out,
  output logic timer_one_osc_enable_out,
  output logic port_hold_out,
  output logic device_reset_out,
  output logic irq_out
);

  localparam int OST_CYC = `SWC_OST_PERIODS;

  swc_pkg::swc_state_e state;
  logic [10:0] ost_cnt;
  logic [1:0] dmy_cnt;
  logic [7:0] ctrl, change_mask, core_irq, pie_one, pie_two, pir_one, pir_two, evt, evt_mask;
  logic pd_flag, to_flag, vec_pending;
  logic [2:0] master_clear_pin_s, ext_s;
  logic [7:0] pb_s1, pb_s2, pb_last;
  logic wb_hit, wb_wr, wake_src, enter_ok, enter_nop, osc_crystal;
  logic [7:0] ev_set;

  // Clear-on-one with set winning
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set, input logic [7:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // Synchronisers; first stage read only by second
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      master_clear_pin_s <= 3'h7;
      ext_s <= 3'h0;
      pb_s1 <= 8'h00;
      pb_s2 <= 8'h00;
      pb_last <= 8'h00;
    end else begin
      master_clear_pin_s <= {master_clear_pin_s[1:0], master_clear_pin_in};
      ext_s <= {ext_s[1:0], ext_pin_in};
      pb_s1 <= portb_in;
      pb_s2 <= pb_s1;
      pb_last <= pb_s2;
    end
  end

  wire master_clear_pin_low = !master_clear_pin_s[1];
  wire ext_rise = ext_s[1] & !ext_s[2];
  wire pb_change = |((pb_s2 ^ pb_last) & change_mask);

  // Wake sources gated by their enables, global enable ignored
  always_comb begin
    wake_src = (core_irq[`SWC_CI_EXT_PIN_IRQ_ENABLE] & core_irq[`SWC_CI_EXT_PIN_IRQ_FLAG])
      | (core_irq[`SWC_CI_PORTB_CHANGE_ENABLE] & core_irq[`SWC_CI_PORTB_CHANGE_FLAG])
      | (ctrl[`SWC_CTRL_T1_ASYNC] & pie_one[`SWC_P1_TIMER_ONE] & pir_one[`SWC_P1_TIMER_ONE])
      | (ctrl[`SWC_CTRL_RX_SLAVE] & pie_one[`SWC_P1_RC] & pir_one[`SWC_P1_RC])
      | (ctrl[`SWC_CTRL_AD_RC] & pie_one[`SWC_P1_AD] & pir_one[`SWC_P1_AD])
      | (pie_one[`SWC_P1_CAPTURE_UNIT_ONE] & pir_one[`SWC_P1_CAPTURE_UNIT_ONE])
      | (pie_two[0] & pir_two[0])
      | (ctrl[`SWC_CTRL_SSP_SLAVE] & pie_one[`SWC_P1_SSP] & pir_one[`SWC_P1_SSP]);
  end

  assign enter_nop = (state == swc_pkg::SWC_RUN) & sleep_instr_in & wake_src & !core_irq[`SWC_CI_GIE];
  assign enter_ok = (state == swc_pkg::SWC_RUN) & sleep_instr_in & !enter_nop;
  assign osc_crystal = (ctrl[`SWC_CTRL_OSC_HI:`SWC_CTRL_OSC_LO] == swc_pkg::SWC_OSC_LP)
    | (ctrl[`SWC_CTRL_OSC_HI:`SWC_CTRL_OSC_LO] == swc_pkg::SWC_OSC_XT)
    | (ctrl[`SWC_CTRL_OSC_HI:`SWC_CTRL_OSC_LO] == swc_pkg::SWC_OSC_HS);
  wire wdt_wake = (state == swc_pkg::SWC_SLEEP) & wdt_timeout_in & ctrl[`SWC_CTRL_WDT_EN];
  wire irq_wake = (state == swc_pkg::SWC_SLEEP) & wake_src & !wdt_wake;
  wire waking = wdt_wake | irq_wake;
  wire next_from_wake = osc_crystal ? 1'b1 : 1'b0;

  // Sleep sequencer
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= swc_pkg::SWC_RUN;
      ost_cnt <= 11'h000;
      dmy_cnt <= 2'h0;
      vec_pending <= 1'b0;
    end else if (master_clear_pin_low) begin
      state <= swc_pkg::SWC_RUN;
      vec_pending <= 1'b0;
    end else begin
      case (state)
        swc_pkg::SWC_RUN: begin
          if (enter_ok) state <= swc_pkg::SWC_SLEEP;
        end
        swc_pkg::SWC_SLEEP: begin
          if (waking) begin
            vec_pending <= irq_wake & core_irq[`SWC_CI_GIE];
            ost_cnt <= 11'h000;
            state <= next_from_wake ? swc_pkg::SWC_OST : swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_OST: begin
          ost_cnt <= ost_cnt + 11'h001;
          if (ost_cnt == 11'(OST_CYC - 1)) state <= swc_pkg::SWC_RESUME;
        end
        swc_pkg::SWC_RESUME: begin
          dmy_cnt <= 2'h0;
          state <= vec_pending ? swc_pkg::SWC_DUMMY : swc_pkg::SWC_RUN;
        end
        swc_pkg::SWC_DUMMY: begin
          dmy_cnt <= dmy_cnt + 2'h1;
          if (dmy_cnt == 2'(`SWC_DUMMY_CYCLES - 1)) begin
            state <= swc_pkg::SWC_RUN;
            vec_pending <= 1'b0;
          end
        end
        default: state <= swc_pkg::SWC_RUN;
      endcase
    end
  end

  // Power-down and timeout flags
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_flag <= 1'b1;
      to_flag <= 1'b1;
    end else if (master_clear_pin_low) begin
      pd_flag <= 1'b1;
      to_flag <= 1'b1;
    end else if (enter_ok) begin
      pd_flag <= 1'b0;
      to_flag <= 1'b1;
    end else if (wdt_wake) begin
      to_flag <= 1'b0;
    end
  end

  // Core and watchdog strobes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wdt_clear_out <= 1'b0;
      wdt_reset_out <= 1'b0;
      prefetch_out <= 1'b0;
      prefetch_addr_out <= 13'h0000;
      resume_out <= 1'b0;
      vector_out <= 1'b0;
      vector_addr_out <= 13'h0000;
      dummy_cycle_out <= 1'b0;
      device_reset_out <= 1'b0;
    end else begin
      wdt_clear_out <= (enter_ok & ctrl[`SWC_CTRL_WDT_EN]) | waking;
      wdt_reset_out <= (state == swc_pkg::SWC_RUN) & wdt_timeout_in & ctrl[`SWC_CTRL_WDT_EN];
      prefetch_out <= enter_ok;
      if (enter_ok) prefetch_addr_out <= pc_in + 13'h0001;
      resume_out <= (state == swc_pkg::SWC_RESUME);
      vector_out <= (state == swc_pkg::SWC_DUMMY) && (dmy_cnt == 2'(`SWC_DUMMY_CYCLES - 1));
      vector_addr_out <= `SWC_VECTOR;
      dummy_cycle_out <= (state == swc_pkg::SWC_DUMMY);
      device_reset_out <= master_clear_pin_low;
    end
  end

  wire sleeping = (state == swc_pkg::SWC_SLEEP);
  assign core_hold_out = (state != swc_pkg::SWC_RUN);
  assign main_osc_enable_out = !sleeping;
  assign timer_one_osc_enable_out = 1'b1;
  assign port_hold_out = sleeping;

  // Bus decode
  assign wb_hit = wb_cyc_in & wb_stb_in & !wb_ack_out;
  assign wb_wr = wb_hit & wb_we_in & wb_sel_in[0];
  always_comb begin
    ev_set = 8'h00;
    ev_set[`SWC_EV_ENTER] = enter_ok;
    ev_set[`SWC_EV_WAKE_IRQ] = irq_wake;
    ev_set[`SWC_EV_WAKE_WDT] = wdt_wake;
    ev_set[`SWC_EV_NOP] = enter_nop;
  end

  // Software registers, hardware sets win over clears
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= `SWC_RST_CTRL;
      change_mask <= `SWC_RST_REG;
      core_irq <= `SWC_RST_REG;
      pie_one <= `SWC_RST_REG;
      pie_two <= `SWC_RST_REG;
      pir_one <= `SWC_RST_REG;
      pir_two <= `SWC_RST_REG;
      evt <= `SWC_RST_REG;
      evt_mask <= `SWC_RST_REG;
    end else begin
      if (wb_wr && wb_adr_in == `SWC_OFF_CTRL) ctrl <= wb_dat_in[7:0];
      if (wb_wr && wb_adr_in == `SWC_OFF_CHANGE_MASK) change_mask <= wb_dat_in[7:0];
      if (wb_wr && wb_adr_in == `SWC_OFF_PIE_ONE) pie_one <= wb_dat_in[7:0];
      if (wb_wr && wb_adr_in == `SWC_OFF_PIE_TWO) pie_two <= {7'h00, wb_dat_in[0]};
      if (wb_wr && wb_adr_in == `SWC_OFF_EVT_MASK) evt_mask <= wb_dat_in[7:0];
      core_irq <= (wb_wr && wb_adr_in == `SWC_OFF_CORE_IRQ) ? wb_dat_in[7:0] : core_irq;
      core_irq[`SWC_CI_EXT_PIN_IRQ_FLAG] <= ext_rise
        | ((wb_wr && wb_adr_in == `SWC_OFF_CORE_IRQ) ? wb_dat_in[`SWC_CI_EXT_PIN_IRQ_FLAG] : core_irq[`SWC_CI_EXT_PIN_IRQ_FLAG]);
      core_irq[`SWC_CI_PORTB_CHANGE_FLAG] <= pb_change
        | ((wb_wr && wb_adr_in == `SWC_OFF_CORE_IRQ) ? wb_dat_in[`SWC_CI_PORTB_CHANGE_FLAG] : core_irq[`SWC_CI_PORTB_CHANGE_FLAG]);
      pir_one <= w1c(pir_one,
        {1'b0, ad_irq_in, rx_irq_in, 1'b0, sync_serial_port_irq_in, capture_unit_one_irq_in, 1'b0, timer_one_irq_in},
        (wb_wr && wb_adr_in == `SWC_OFF_PIR_ONE) ? wb_dat_in[7:0] : 8'h00);
      pir_two <= w1c(pir_two, {7'h00, capture_unit_two_irq_in},
        (wb_wr && wb_adr_in == `SWC_OFF_PIR_TWO) ? wb_dat_in[7:0] : 8'h00);
      evt <= w1c(evt, ev_set, (wb_wr && wb_adr_in == `SWC_OFF_EVT) ? wb_dat_in[7:0] : 8'h00);
    end
  end

  // Read data and one-cycle ack
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= wb_hit;
      if (wb_hit) begin
        case (wb_adr_in)
          `SWC_OFF_CTRL: wb_dat_out <= {24'h000000, ctrl};
          `SWC_OFF_STATUS: wb_dat_out <= {29'h00000000, sleeping, to_flag, pd_flag};
          `SWC_OFF_CHANGE_MASK: wb_dat_out <= {24'h000000, change_mask};
          `SWC_OFF_CORE_IRQ: wb_dat_out <= {24'h000000, core_irq};
          `SWC_OFF_PIE_ONE: wb_dat_out <= {24'h000000, pie_one};
          `SWC_OFF_PIE_TWO: wb_dat_out <= {24'h000000, pie_two};
          `SWC_OFF_PIR_ONE: wb_dat_out <= {24'h000000, pir_one};
          `SWC_OFF_PIR_TWO: wb_dat_out <= {24'h000000, pir_two};
          `SWC_OFF_EVT: wb_dat_out <= {24'h000000, evt};
          `SWC_OFF_EVT_MASK: wb_dat_out <= {24'h000000, evt_mask};
          default: wb_dat_out <= 32'h00000000;
        endcase
      end
    end
  end

  assign irq_out = |(evt & evt_mask);

  // Cycles spent in the start-up delay, counted for the length check
  logic [10:0] ost_len;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ost_len <= 11'h000;
    end else if (state == swc_pkg::SWC_OST) begin
      ost_len <= ost_len + 11'h001;
    end else begin
      ost_len <= 11'h000;
    end
  end

  // Checks on sleep entry
  a_enter_flags: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    enter_ok && !master_clear_pin_low |=> !pd_flag && to_flag)
    else $error("sleep entry flags wrong");
  a_sleep_cause: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(state == swc_pkg::SWC_SLEEP) |-> $past(sleep_instr_in))
    else $error("sleep without instruction");
  a_pd_cause: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(pd_flag) |-> $past(sleep_instr_in))
    else $error("power-down flag cleared without instruction");
  a_wdt_entry: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    enter_ok && ctrl[`SWC_CTRL_WDT_EN] |=> wdt_clear_out)
    else $error("watchdog not cleared on entry");
  a_prefetch_pc: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    enter_ok |=> prefetch_out && prefetch_addr_out == $past(pc_in) + 13'h0001)
    else $error("prefetch");
  a_nop_flags: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    enter_nop && !master_clear_pin_low |=> state == swc_pkg::SWC_RUN && $stable(pd_flag))
    else $error("no-op sleep");

  // Checks while asleep
  a_osc_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    sleeping |-> !main_osc_enable_out && timer_one_osc_enable_out && port_hold_out)
    else $error("osc gate");
  a_port_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(port_hold_out) |-> $past(enter_ok))
    else $error("port hold outside sleep entry");
  a_stay_asleep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    sleeping && !waking && !master_clear_pin_low |=> sleeping)
    else $error("woke without a source");
  a_wake_any_gie: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    sleeping && wake_src && !master_clear_pin_low |=> !sleeping)
    else $error("enabled source did not wake");

  // Checks on wake-up
  a_wake_clear: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    waking && !master_clear_pin_low |=> wdt_clear_out)
    else $error("watchdog not cleared on wake");
  a_irq_flags: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    irq_wake && !master_clear_pin_low |=> !pd_flag && to_flag)
    else $error("flags changed on interrupt wake");
  a_wdt_wake_to: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wdt_wake && !master_clear_pin_low |=> !to_flag)
    else $error("timeout flag not cleared");
  a_vec_choice: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    irq_wake && !master_clear_pin_low |=> vec_pending == $past(core_irq[`SWC_CI_GIE]))
    else $error("resume path does not follow global enable");
  a_vector_dummy: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    vector_out |-> $past(dummy_cycle_out) && vector_addr_out == 13'h0004)
    else $error("vector path");

  // Checks on the start-up delay
  a_ost_length: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(state == swc_pkg::SWC_OST) && state == swc_pkg::SWC_RESUME |-> ost_len == 11'(`SWC_OST_PERIODS))
    else $error("ost length");
  a_ost_bound: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state == swc_pkg::SWC_OST |-> ost_len < 11'(`SWC_OST_PERIODS))
    else $error("ost overrun");
  a_no_ost: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    waking && !osc_crystal && !master_clear_pin_low |=> state == swc_pkg::SWC_RESUME)
    else $error("delay in ec or rc");

  // Checks on master clear
  a_master_clear_pin_run: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    master_clear_pin_low |=> state == swc_pkg::SWC_RUN && pd_flag && to_flag)
    else $error("master clear did not reset");
  a_dev_reset_cause: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(device_reset_out) |-> $past(master_clear_pin_low))
    else $error("device reset without master clear");

  // Main scenarios reached
  c_irq_wake: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    irq_wake);
  c_wdt_wake: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wdt_wake);
  c_nop_sleep: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    enter_nop);
  c_vector: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    vector_out);
  c_ost_done: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(state == swc_pkg::SWC_OST));

endmodule : swc_sleep_wake_control

/* File: testbench/swc_core_model.sv */
// Partner model: processor core issuing the power-down instruction, watchdog and wake sources.
// Assumes the bench calls its tasks from one process, on the system clock.
`timescale 1ns/100ps
module swc_core_model (
  // Clock
  input wire logic clk_in,
  // Core side
  output logic sleep_instr_out,
  output logic [12:0] pc_out,
  // Watchdog and pins
  output logic wdt_timeout_out,
  output logic master_clear_pin_out,
  output logic ext_pin_out,
  output logic [7:0] portb_out,
  // Peripheral requests: timer one, receive, converter, capture one, capture two, serial port
  output logic [5:0] src_out
);
  // Idle levels: master clear released high, no requests
  initial begin
    sleep_instr_out = 1'b0;
    pc_out = 13'h0000;
    wdt_timeout_out = 1'b0;
    master_clear_pin_out = 1'b1;
    ext_pin_out = 1'b0;
    portb_out = 8'h5a;
    src_out = 6'h00;
  end

  // Power-down instruction at address p; watchdog was cleared and the next word is a no-op
  task run_sleep(input logic [12:0] p);
    @(posedge clk_in);
    sleep_instr_out <= 1'b1;
    pc_out <= p;
    @(posedge clk_in);
    sleep_instr_out <= 1'b0;
    pc_out <= ~p; // No stale address left behind
  endtask : run_sleep

  // Request on source i for n cycles: 0 to 5 peripherals, 6 watchdog, 7 external pin
  task pulse(input int i, input int n);
    @(posedge clk_in);
    if (i == 6) wdt_timeout_out <= 1'b1;
    else if (i == 7) ext_pin_out <= 1'b1;
    else src_out[i] <= 1'b1;
    repeat (n) @(posedge clk_in);
    wdt_timeout_out <= 1'b0;
    ext_pin_out <= 1'b0;
    src_out <= 6'h00;
  endtask : pulse

  // Master clear pin held low for n cycles
  task clear_pin(input int n);
    @(posedge clk_in);
    master_clear_pin_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    master_clear_pin_out <= 1'b1;
  endtask : clear_pin

  // Flip the port pins selected by m
  task flip_portb(input logic [7:0] m);
    @(posedge clk_in);
    portb_out <= portb_out ^ m;
  endtask : flip_portb
endmodule : swc_core_model

/* File: testbench/swc_sleep_wake_control_test.sv */
// Self-checking bench of the sleep and wake controller: Wishbone tasks and sleep scenarios.
// Assumes the partner model drives the core, watchdog and wake sources.
`timescale 1ns/100ps
`include "swc_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module swc_sleep_wake_control_test;
  logic sys_clk_in, reset_n_in, cyc, stb, we, ack, sleep_i, wdt_to, master_clear_pin, ext;
  logic hold, pref, res, vec, dum, wclr, wrst, mosc, tosc, phold, drst, irq;
  logic [7:0] adr, portb;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, got;
  logic [12:0] pc, paddr, vaddr;
  logic [5:0] src;
  int miscompares = 0, num_checks = 0, waited, c, v;
  int n_res = 0, n_vec = 0, n_dum = 0, n_clr = 0, n_rst = 0, n_pref = 0;

  swc_sleep_wake_control dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .sleep_instr_in(sleep_i), .pc_in(pc), .core_hold_out(hold),
    .prefetch_out(pref), .prefetch_addr_out(paddr), .resume_out(res), .vector_out(vec),
    .vector_addr_out(vaddr), .dummy_cycle_out(dum), .wdt_timeout_in(wdt_to), .wdt_clear_out(wclr),
    .wdt_reset_out(wrst), .master_clear_pin_in(master_clear_pin), .ext_pin_in(ext), .portb_in(portb),
    .timer_one_irq_in(src[0]), .rx_irq_in(src[1]), .ad_irq_in(src[2]), .capture_unit_one_irq_in(src[3]),
    .capture_unit_two_irq_in(src[4]), .sync_serial_port_irq_in(src[5]), .main_osc_enable_out(mosc),
    .timer_one_osc_enable_out(tosc), .port_hold_out(phold), .device_reset_out(drst), .irq_out(irq));
  swc_core_model mdl (.clk_in(sys_clk_in), .sleep_instr_out(sleep_i), .pc_out(pc),
    .wdt_timeout_out(wdt_to), .master_clear_pin_out(master_clear_pin), .ext_pin_out(ext), .portb_out(portb),
    .src_out(src));

  // Clock at 20 MHz
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // Count cycles of each core and watchdog strobe
  always @(posedge sys_clk_in) begin
    if (res === 1'b1) n_res <= n_res + 1;
    if (vec === 1'b1) n_vec <= n_vec + 1;
    if (dum === 1'b1) n_dum <= n_dum + 1;
    if (wclr === 1'b1) n_clr <= n_clr + 1;
    if (wrst === 1'b1) n_rst <= n_rst + 1;
    if (pref === 1'b1) n_pref <= n_pref + 1;
  end

  // Verdict and end of run
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Classic Wishbone cycle, held until ack is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      miscompares++;
      give_verdict();
    end
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(1'b0, a, 32'h00000000);
    `CHK(nm, {24'h000000, e}, got)
  endtask : rd

  // Bounded wait until counter cnt reaches tgt; waited holds the cycles spent
  task automatic wait_cnt(ref int cnt, input int tgt);
    waited = 0;
    while (cnt < tgt && waited < 2000) begin
      @(negedge sys_clk_in);
      waited++;
    end
    if (waited >= 2000) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_cnt

  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h00000000;
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd(`SWC_OFF_STATUS, 8'h03, "status_reset");
    rd(`SWC_OFF_CTRL, 8'h01, "ctrl_reset");
    rd(8'h40, 8'h00, "unmapped");
    // Write with the low byte lane off is ignored
    sel <= 4'he;
    wr(`SWC_OFF_CTRL, 8'h00);
    sel <= 4'hf;
    rd(`SWC_OFF_CTRL, 8'h01, "sel_refused");
    `CHK("hold_run", 1'b0, hold)
    // Entry in external clock mode; receive enabled but not in slave mode, timer one disabled
    wr(`SWC_OFF_CTRL, 8'h07);
    wr(`SWC_OFF_EVT_MASK, 8'h01);
    wr(`SWC_OFF_PIE_ONE, 8'h20);
    c = n_clr;
    mdl.run_sleep(13'h0123);
    repeat (2) @(negedge sys_clk_in);
    `CHK("prefetch_addr", 13'h0124, paddr)
    `CHK("prefetch_cnt", 1, n_pref)
    `CHK("wdt_clear_entry", c + 1, n_clr)
    `CHK("hold_sleep", 1'b1, hold)
    `CHK("main_osc", 1'b0, mosc)
    `CHK("timer_osc", 1'b1, tosc)
    `CHK("port_hold", 1'b1, phold)
    `CHK("irq_enter", 1'b1, irq)
    rd(`SWC_OFF_STATUS, 8'h06, "status_sleep");
    mdl.pulse(1, 1);
    mdl.pulse(0, 1);
    repeat (6) @(negedge sys_clk_in);
    `CHK("no_wake", 1'b1, hold)
    wr(`SWC_OFF_CORE_IRQ, 8'h10);
    v = n_vec;
    mdl.pulse(7, 3);
    wait_cnt(n_res, 1);
    `CHK("inline_no_vector", v, n_vec)
    `CHK("wdt_clear_wake", c + 2, n_clr)
    `CHK("osc_back", 1'b1, mosc)
    rd(`SWC_OFF_EVT, 8'h03, "evt_irq_wake");
    wr(`SWC_OFF_EVT, 8'h0f);
    `CHK("irq_cleared", 1'b0, irq)
    wr(`SWC_OFF_CORE_IRQ, 8'h00);
    wr(`SWC_OFF_PIR_ONE, 8'hff);
    // Global enable set: capture one wakes, dummies, then vector
    wr(`SWC_OFF_PIE_ONE, 8'h04);
    wr(`SWC_OFF_CORE_IRQ, 8'h80);
    mdl.run_sleep(13'h0200);
    mdl.pulse(3, 1);
    wait_cnt(n_vec, v + 1);
    `CHK("dummy_cycles", 2, n_dum)
    `CHK("vector_addr", 13'h0004, vaddr)
    wr(`SWC_OFF_PIR_ONE, 8'hff);
    wr(`SWC_OFF_CORE_IRQ, 8'h00);
    // Watchdog wake with the event interrupt masked
    wr(`SWC_OFF_EVT_MASK, 8'h00);
    mdl.run_sleep(13'h0300);
    mdl.pulse(6, 1);
    wait_cnt(n_res, 3);
    rd(`SWC_OFF_STATUS, 8'h00, "status_wdt_wake");
    `CHK("irq_masked", 1'b0, irq)
    // Crystal mode: start-up delay before resuming
    wr(`SWC_OFF_CTRL, 8'h03);
    mdl.run_sleep(13'h0400);
    mdl.pulse(6, 1);
    wait_cnt(n_res, 4);
    `CHK("ost_delay", 1'b1, waited >= 1023 && waited <= 1030)
    // Watchdog timeout while running
    c = n_rst;
    mdl.pulse(6, 1);
    repeat (3) @(negedge sys_clk_in);
    `CHK("wdt_reset", c + 1, n_rst)
    `CHK("no_dev_reset", 1'b0, drst)
    // Master clear during sleep
    wr(`SWC_OFF_CTRL, 8'h07);
    mdl.run_sleep(13'h0500);
    mdl.clear_pin(4);
    @(negedge sys_clk_in);
    `CHK("dev_reset", 1'b1, drst)
    `CHK("hold_master_clear_pin", 1'b0, hold)
    repeat (6) @(negedge sys_clk_in);
    rd(`SWC_OFF_STATUS, 8'h03, "status_master_clear_pin");
    // Enabled flag pending with global enable clear: sleep is a no-op
    wr(`SWC_OFF_CTRL, 8'h07);
    wr(`SWC_OFF_EVT, 8'h0f);
    wr(`SWC_OFF_CORE_IRQ, 8'h10);
    mdl.pulse(7, 3);
    repeat (4) @(negedge sys_clk_in);
    c = n_clr;
    mdl.run_sleep(13'h0600);
    repeat (2) @(negedge sys_clk_in);
    `CHK("nop_hold", 1'b0, hold)
    `CHK("nop_no_clear", c, n_clr)
    rd(`SWC_OFF_STATUS, 8'h03, "status_nop");
    rd(`SWC_OFF_EVT, 8'h08, "evt_nop");
    // Port change, converter, capture two and serial port each wake
    wr(`SWC_OFF_CORE_IRQ, 8'h08);
    wr(`SWC_OFF_CHANGE_MASK, 8'h01);
    wr(`SWC_OFF_CTRL, 8'hc7);
    wr(`SWC_OFF_PIE_ONE, 8'h48);
    wr(`SWC_OFF_PIE_TWO, 8'h01);
    for (int i = 0; i < 4; i++) begin
      c = n_res;
      mdl.run_sleep(13'h0700);
      if (i == 0) mdl.flip_portb(8'h01);
      else mdl.pulse(i == 1 ? 2 : i == 2 ? 4 : 5, 1);
      wait_cnt(n_res, c + 1);
      `CHK("periph_wake", c + 1, n_res)
      wr(`SWC_OFF_CORE_IRQ, 8'h08);
      wr(`SWC_OFF_PIR_ONE, 8'hff);
      wr(`SWC_OFF_PIR_TWO, 8'hff);
    end
    give_verdict();
  end
endmodule : swc_sleep_wake_control_test
